// ===== rtl/cldiv_defines.svh
// Register indices, status bit positions, reset values and timing counts of the divider
`ifndef CLDIV_DEFINES_SVH
`define CLDIV_DEFINES_SVH

// Register indices on the core-local access port
`define CLDIV_IDX_CTRL_STATUS 3'h0
`define CLDIV_IDX_UNSIGNED_NUM 3'h1
`define CLDIV_IDX_UNSIGNED_DEN 3'h2
`define CLDIV_IDX_SIGNED_NUM 3'h3
`define CLDIV_IDX_SIGNED_DEN 3'h4
`define CLDIV_IDX_QUOTIENT 3'h5
`define CLDIV_IDX_REMAINDER 3'h6

// Fields of divider_ctrl_status
`define CLDIV_READY_BIT 0
`define CLDIV_DIRTY_BIT 1

// Reset values
`define CLDIV_RST_WORD 32'h0000_0000
`define CLDIV_RST_READY 1'b1
`define CLDIV_RST_DIRTY 1'b0

// Timing: cycles of calculation and quotient bits retired per cycle
`define CLDIV_LATENCY_CYC 4'h8
`define CLDIV_BITS_PER_CYC 4

`endif

// ===== rtl/cldiv_pkg.sv
// Types shared by the divider design files
package cldiv_pkg;

    typedef enum logic [0:0] {
        CLDIV_IDLE = 1'b0,
        CLDIV_BUSY = 1'b1
    } cldiv_state_t;

    typedef logic [31:0] cldiv_word_t;

endpackage

// ===== rtl/cldiv_step.sv
// One restoring division step: shifts in a numerator bit, retires a quotient bit
`timescale 1ns/10ps
module cldiv_step (
    // Partial state in
    input wire logic [31:0] rem_i,
    input wire logic [31:0] quo_i,
    input wire logic [31:0] den_i,
    // Partial state out
    output logic [31:0] rem_o,
    output logic [31:0] quo_o
);
    logic [32:0] trial;
    logic [32:0] diff;

    assign trial = {rem_i, quo_i[31]};
    assign diff = trial - {1'b0, den_i};
    // A zero divisor always subtracts, so the result is fixed, never a stall
    assign rem_o = diff[32] ? trial[31:0] : diff[31:0];
    assign quo_o = {quo_i[30:0], ~diff[32]};
endmodule // cldiv_step

// ===== rtl/cldiv_top.sv
// Core-local 32-bit signed/unsigned divider with save/restore support
//
// Summary of operation
// - Each core owns a divider giving quotient and remainder, signed or unsigned, in 8 cycles.
// - After an operand write the divider computes for 8 cycles; results are valid from the 9th.
// - A ready bit in divider_ctrl_status can be polled to see that the calculation is done.
// - Writing a signed alias starts a signed division, an unsigned alias an unsigned one.
// - Every operand write restarts the calculation at once, squashing any in progress.
// - The divisor is kept, so writing only a dividend starts a division of that alias's sign.
// - Quotient and remainder registers are writable so saved state can be restored.
// - A write to a result register cancels any calculation so the written value stays.
// - The dirty bit is set by any write to an operand or result register.
// - Reading the quotient register clears the dirty bit.
// - Every register read or write completes in one cycle with no wait state.
`timescale 1ns/10ps
`include "cldiv_defines.svh"
module cldiv_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Core-local register access
    input wire logic acc_sel_i,
    input wire logic acc_wr_i,
    input wire logic [2:0] acc_idx_i,
    input wire logic [31:0] acc_wdata_i,
    output logic [31:0] acc_rdata_o,
    // Status and results
    output logic ready_o,
    output logic dirty_o,
    output logic [31:0] quotient_o,
    output logic [31:0] remainder_o
);
    localparam int STEPS = `CLDIV_BITS_PER_CYC;

    cldiv_pkg::cldiv_state_t state_r;
    cldiv_pkg::cldiv_state_t state_nxt;
    logic [3:0] cnt_r;
    cldiv_pkg::cldiv_word_t num_r;
    cldiv_pkg::cldiv_word_t den_r;
    cldiv_pkg::cldiv_word_t wrem_r;
    cldiv_pkg::cldiv_word_t wquo_r;
    cldiv_pkg::cldiv_word_t wden_r;
    logic neg_q_r;
    logic neg_r_r;
    cldiv_pkg::cldiv_word_t quot_r;
    cldiv_pkg::cldiv_word_t rem_r;
    logic ready_r;
    logic dirty_r;
    logic [31:0] rdata_r;

    // Decoded accesses
    logic wr_en;
    logic rd_en;
    logic wr_num;
    logic wr_den;
    logic wr_signed;
    logic start;
    logic wr_quot;
    logic wr_rem;
    logic last;

    assign wr_en = ce_i & acc_sel_i & acc_wr_i;
    assign rd_en = ce_i & acc_sel_i & ~acc_wr_i;
    assign wr_num = wr_en & ((acc_idx_i == `CLDIV_IDX_UNSIGNED_NUM) |
                             (acc_idx_i == `CLDIV_IDX_SIGNED_NUM));
    assign wr_den = wr_en & ((acc_idx_i == `CLDIV_IDX_UNSIGNED_DEN) |
                             (acc_idx_i == `CLDIV_IDX_SIGNED_DEN));
    assign wr_signed = (acc_idx_i == `CLDIV_IDX_SIGNED_NUM) |
                       (acc_idx_i == `CLDIV_IDX_SIGNED_DEN);
    assign start = wr_num | wr_den;
    assign wr_quot = wr_en & (acc_idx_i == `CLDIV_IDX_QUOTIENT);
    assign wr_rem = wr_en & (acc_idx_i == `CLDIV_IDX_REMAINDER);
    assign last = (state_r == cldiv_pkg::CLDIV_BUSY) &
                  (cnt_r == (`CLDIV_LATENCY_CYC - 4'h1));

    // Operands of the new division: written word plus the kept other operand
    cldiv_pkg::cldiv_word_t op_num;
    cldiv_pkg::cldiv_word_t op_den;
    logic op_neg_num;
    logic op_neg_den;

    assign op_num = wr_num ? acc_wdata_i : num_r;
    assign op_den = wr_den ? acc_wdata_i : den_r;
    assign op_neg_num = wr_signed & op_num[31];
    assign op_neg_den = wr_signed & op_den[31];

    // Datapath: a chain of restoring steps per cycle
    logic [31:0] chain_rem [0:STEPS];
    logic [31:0] chain_quo [0:STEPS];

    assign chain_rem[0] = wrem_r;
    assign chain_quo[0] = wquo_r;

    genvar g;
    generate
        for (g = 0; g < STEPS; g++) begin : g_step
            cldiv_step u_step (
                .rem_i(chain_rem[g]),
                .quo_i(chain_quo[g]),
                .den_i(wden_r),
                .rem_o(chain_rem[g + 1]),
                .quo_o(chain_quo[g + 1])
            );
        end
    endgenerate

    // Sign fixup on the final step
    cldiv_pkg::cldiv_word_t fin_quo;
    cldiv_pkg::cldiv_word_t fin_rem;

    assign fin_quo = neg_q_r ? (~chain_quo[STEPS]) + 32'h0000_0001 : chain_quo[STEPS];
    assign fin_rem = neg_r_r ? (~chain_rem[STEPS]) + 32'h0000_0001 : chain_rem[STEPS];

    // Sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cldiv_pkg::CLDIV_IDLE: begin
                if (start) begin
                    state_nxt = cldiv_pkg::CLDIV_BUSY;
                end
            end
            cldiv_pkg::CLDIV_BUSY: begin
                if (start) begin
                    state_nxt = cldiv_pkg::CLDIV_BUSY;
                end else if (wr_quot | wr_rem) begin
                    state_nxt = cldiv_pkg::CLDIV_IDLE;
                end else if (last) begin
                    state_nxt = cldiv_pkg::CLDIV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= cldiv_pkg::CLDIV_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // Cycle count restarts with every operand write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
        end else if (ce_i) begin
            if (start) begin
                cnt_r <= 4'h0;
            end else if (state_r == cldiv_pkg::CLDIV_BUSY) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end

    // Kept operands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            num_r <= `CLDIV_RST_WORD;
            den_r <= `CLDIV_RST_WORD;
        end else if (ce_i) begin
            if (wr_num) begin
                num_r <= acc_wdata_i;
            end
            if (wr_den) begin
                den_r <= acc_wdata_i;
            end
        end
    end

    // Working magnitudes; signs are resolved up front to keep the loop unsigned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrem_r <= `CLDIV_RST_WORD;
            wquo_r <= `CLDIV_RST_WORD;
            wden_r <= `CLDIV_RST_WORD;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
        end else if (ce_i) begin
            if (start) begin
                wrem_r <= `CLDIV_RST_WORD;
                wquo_r <= op_neg_num ? (~op_num) + 32'h0000_0001 : op_num;
                wden_r <= op_neg_den ? (~op_den) + 32'h0000_0001 : op_den;
                neg_q_r <= op_neg_num ^ op_neg_den;
                neg_r_r <= op_neg_num;
            end else if (state_r == cldiv_pkg::CLDIV_BUSY) begin
                wrem_r <= chain_rem[STEPS];
                wquo_r <= chain_quo[STEPS];
            end
        end
    end

    // Result registers: loaded on completion or by a restore write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quot_r <= `CLDIV_RST_WORD;
            rem_r <= `CLDIV_RST_WORD;
        end else if (ce_i) begin
            if (wr_quot) begin
                quot_r <= acc_wdata_i;
            end else if (last & ~start & ~wr_rem) begin
                quot_r <= fin_quo;
            end
            if (wr_rem) begin
                rem_r <= acc_wdata_i;
            end else if (last & ~start & ~wr_quot) begin
                rem_r <= fin_rem;
            end
        end
    end

    // Ready flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_r <= `CLDIV_RST_READY;
        end else if (ce_i) begin
            if (start) begin
                ready_r <= 1'b0;
            end else if (wr_quot | wr_rem) begin
                ready_r <= 1'b1;
            end else if (last) begin
                ready_r <= 1'b1;
            end
        end
    end

    // Dirty flag; a write in the same cycle wins over the clearing read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dirty_r <= `CLDIV_RST_DIRTY;
        end else if (ce_i) begin
            if (start | wr_quot | wr_rem) begin
                dirty_r <= 1'b1;
            end else if (rd_en & (acc_idx_i == `CLDIV_IDX_QUOTIENT)) begin
                dirty_r <= 1'b0;
            end
        end
    end

    // Read data, one cycle after the access; unmapped index reads zero
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = `CLDIV_RST_WORD;
        unique case (acc_idx_i)
            `CLDIV_IDX_CTRL_STATUS: begin
                rd_mux[`CLDIV_READY_BIT] = ready_r;
                rd_mux[`CLDIV_DIRTY_BIT] = dirty_r;
            end
            `CLDIV_IDX_UNSIGNED_NUM, `CLDIV_IDX_SIGNED_NUM: begin
                rd_mux = num_r;
            end
            `CLDIV_IDX_UNSIGNED_DEN, `CLDIV_IDX_SIGNED_DEN: begin
                rd_mux = den_r;
            end
            `CLDIV_IDX_QUOTIENT: begin
                rd_mux = quot_r;
            end
            `CLDIV_IDX_REMAINDER: begin
                rd_mux = rem_r;
            end
            default: begin
                rd_mux = `CLDIV_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= `CLDIV_RST_WORD;
        end else if (rd_en) begin
            rdata_r <= rd_mux;
        end
    end

    assign acc_rdata_o = rdata_r;
    assign ready_o = ready_r;
    assign dirty_o = dirty_r;
    assign quotient_o = quot_r;
    assign remainder_o = rem_r;
endmodule // cldiv_top

// ===== verif/cldiv_core_model.sv
// Processor core model driving the divider access port
`timescale 1ns/10ps
module cldiv_core_model (
    // Clock
    input wire logic clk_i,
    // Access port
    output logic acc_sel_o,
    output logic acc_wr_o,
    output logic [2:0] acc_idx_o,
    output logic [31:0] acc_wdata_o,
    input wire logic [31:0] acc_rdata_i
);
    initial begin
        acc_sel_o = 1'b0;
        acc_wr_o = 1'b0;
        acc_idx_o = 3'h0;
        acc_wdata_o = 32'h0000_0000;
    end
    // One access per cycle, never a wait state
    task automatic put(input logic w, input logic [2:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        acc_sel_o <= 1'b1;
        acc_wr_o <= w;
        acc_idx_o <= idx;
        acc_wdata_o <= d;
    endtask
    // Other work only; data line toggles so a stale word is never reused
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_i);
            acc_sel_o <= 1'b0;
            acc_wdata_o <= ~acc_wdata_o;
        end
    endtask
    task automatic get(input logic [2:0] idx, output logic [31:0] d);
        put(1'b0, idx, 32'h0000_0000);
        idle(1);
        #1;
        d = acc_rdata_i;
    endtask
endmodule // cldiv_core_model

// ===== verif/cldiv_top_asserts.sv
// Port assertions for the divider
`timescale 1ns/10ps
module cldiv_top_asserts (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register access
    input wire logic acc_sel_i,
    input wire logic acc_wr_i,
    input wire logic [2:0] acc_idx_i,
    input wire logic [31:0] acc_wdata_i,
    input wire logic [31:0] acc_rdata_o,
    // Status and results
    input wire logic ready_o,
    input wire logic dirty_o,
    input wire logic [31:0] quotient_o,
    input wire logic [31:0] remainder_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic wr_w = ce_i && acc_sel_i && acc_wr_i;
    wire logic rd_w = ce_i && acc_sel_i && !acc_wr_i;
    wire logic op_w = wr_w && acc_idx_i >= 3'h1 && acc_idx_i <= 3'h4;
    wire logic res_w = wr_w && (acc_idx_i == 3'h5 || acc_idx_i == 3'h6);
    sequence s_start;
        op_w;
    endsequence
    // Restarts and cancels would void the count
    sequence s_quiet;
        ce_i && !op_w && !res_w;
    endsequence
    property p_drop;
        s_start |=> !ready_o;
    endproperty
    property p_busy;
        s_start ##1 s_quiet [*7] |-> !ready_o;
    endproperty
    property p_done;
        s_start ##1 s_quiet [*8] |=> ready_o;
    endproperty
    property p_cancel;
        res_w |=> ready_o;
    endproperty
    property p_restore;
        res_w |=> (($past(acc_idx_i) == 3'h5) ? quotient_o : remainder_o) == $past(acc_wdata_i);
    endproperty
    property p_dirty_set;
        op_w || res_w |=> dirty_o;
    endproperty
    property p_dirty_clr;
        rd_w && acc_idx_i == 3'h5 |=> !dirty_o;
    endproperty
    property p_rd_ctrl;
        rd_w && acc_idx_i == 3'h0 && ready_o |=> acc_rdata_o == {30'h0, $past(dirty_o), 1'b1};
    endproperty
    property p_rd_quo;
        rd_w && acc_idx_i == 3'h5 && ready_o |=> acc_rdata_o == $past(quotient_o);
    endproperty
    a_drop: assert property (p_drop) else $error("ready kept high after a start");
    a_busy: assert property (p_busy) else $error("ready rose early");
    a_done: assert property (p_done) else $error("ready late after eight cycles");
    a_cancel: assert property (p_cancel) else $error("ready low after result write");
    a_restore: assert property (p_restore) else $error("result write lost");
    a_dirty_set: assert property (p_dirty_set) else $error("dirty not set");
    a_dirty_clr: assert property (p_dirty_clr) else $error("dirty not cleared");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("status read wrong");
    a_rd_quo: assert property (p_rd_quo) else $error("quotient read wrong");
endmodule // cldiv_top_asserts
bind cldiv_top cldiv_top_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .acc_sel_i(acc_sel_i), .acc_wr_i(acc_wr_i), .acc_idx_i(acc_idx_i),
    .acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rdata_o), .ready_o(ready_o),
    .dirty_o(dirty_o), .quotient_o(quotient_o), .remainder_o(remainder_o));

// ===== verif/cldiv_top_bench.sv
// Self-checking bench for the core-local divider
`timescale 1ns/10ps
`include "cldiv_defines.svh"
module cldiv_top_bench;
    logic clk_i;
    logic rst_i;
    logic ce_i;
    wire logic sel_w, wr_w, rdy_w, dty_w;
    wire logic [2:0] idx_w;
    wire logic [31:0] wd_w, rd_w, q_w, r_w;
    int err_total = 0;
    int compares = 0;
    logic [31:0] v;
    logic [31:0] tn [4] = '{32'h0000_0064, 32'h0000_0005, 32'h8000_0000, 32'hFFFF_FF9C};
    logic [31:0] td [4] = '{32'h0000_0007, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0007};
    logic [3:0] ts = 4'b1100;
    // Expected results worked by hand; zero divisor gives all ones and the dividend
    logic [31:0] teq [4] = '{32'h0000_000E, 32'hFFFF_FFFF, 32'h8000_0000, 32'hFFFF_FFF2};
    logic [31:0] ter [4] = '{32'h0000_0002, 32'h0000_0005, 32'h0000_0000, 32'hFFFF_FFFE};
    always #25 clk_i = ~clk_i;
    cldiv_core_model u_core (.clk_i(clk_i), .acc_sel_o(sel_w), .acc_wr_o(wr_w),
        .acc_idx_o(idx_w), .acc_wdata_o(wd_w), .acc_rdata_i(rd_w));
    cldiv_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .acc_sel_i(sel_w),
        .acc_wr_i(wr_w), .acc_idx_i(idx_w), .acc_wdata_i(wd_w), .acc_rdata_o(rd_w),
        .ready_o(rdy_w), .dirty_o(dty_w), .quotient_o(q_w), .remainder_o(r_w));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Divisor then dividend back to back: second write restarts the count
    task automatic div_run(input logic s, input logic [31:0] n, input logic [31:0] d,
                           input logic [31:0] eq, input logic [31:0] er);
        u_core.put(1'b1, s ? `CLDIV_IDX_SIGNED_DEN : `CLDIV_IDX_UNSIGNED_DEN, d);
        u_core.put(1'b1, s ? `CLDIV_IDX_SIGNED_NUM : `CLDIV_IDX_UNSIGNED_NUM, n);
        u_core.idle(8);
        #1;
        check("ready busy", {31'h0, rdy_w}, 32'h0000_0000);
        u_core.idle(1);
        #1;
        check("ready done", {31'h0, rdy_w}, 32'h0000_0001);
        check("quotient", q_w, eq);
        u_core.get(`CLDIV_IDX_REMAINDER, v);
        check("remainder read", v, er);
        u_core.get(`CLDIV_IDX_QUOTIENT, v);
        check("quotient read", v, eq);
        check("dirty", {31'h0, dty_w}, 32'h0000_0000);
    endtask
    task automatic t_table;
        u_core.get(`CLDIV_IDX_CTRL_STATUS, v);
        check("status reset", v, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            div_run(ts[i], tn[i], td[i], teq[i], ter[i]);
        end
        // Kept divisor, dividend alias only
        u_core.put(1'b1, `CLDIV_IDX_UNSIGNED_NUM, 32'hFFFF_FF9C);
        u_core.idle(9);
        #1;
        check("kept divisor", q_w, 32'hFFFF_FF9C / 32'h0000_0007);
        $display("table test done");
    endtask
    task automatic t_restore;
        u_core.put(1'b1, `CLDIV_IDX_UNSIGNED_NUM, 32'h0000_0064);
        u_core.idle(3);
        u_core.put(1'b1, `CLDIV_IDX_QUOTIENT, 32'h1234_5678);
        u_core.put(1'b1, `CLDIV_IDX_REMAINDER, 32'hA5A5_0000);
        u_core.idle(10);
        #1;
        check("ready cancel", {31'h0, rdy_w}, 32'h0000_0001);
        check("quotient kept", q_w, 32'h1234_5678);
        check("remainder kept", r_w, 32'hA5A5_0000);
        check("dirty set", {31'h0, dty_w}, 32'h0000_0001);
        u_core.get(`CLDIV_IDX_QUOTIENT, v);
        check("quotient restored read", v, 32'h1234_5678);
        check("dirty cleared", {31'h0, dty_w}, 32'h0000_0000);
        u_core.get(`CLDIV_IDX_UNSIGNED_DEN, v);
        check("divisor read back", v, 32'h0000_0007);
        u_core.get(3'h7, v);
        check("unmapped", v, 32'h0000_0000);
        $display("restore test done");
    endtask
    // Disabled clock: the write must leave no trace
    task automatic t_hold;
        @(posedge clk_i);
        ce_i <= 1'b0;
        u_core.put(1'b1, `CLDIV_IDX_SIGNED_NUM, 32'h0000_0009);
        u_core.idle(1);
        @(posedge clk_i);
        ce_i <= 1'b1;
        u_core.get(`CLDIV_IDX_CTRL_STATUS, v);
        check("status frozen", v, 32'h0000_0001);
        $display("hold test done");
    endtask
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_table();
        t_restore();
        t_hold();
        finish_test();
    end
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule // cldiv_top_bench
